// *** rtl/rx_straddle_pkg.sv ***
/*
 Constants shared by both ends of the straddled receive stream port.
 Assumes one stream clock shared by the device end and the client end.
*/
package rx_straddle_pkg;
	localparam int WORD_W   = 128;
	localparam int SEG_W    = 64;
	localparam int SEGS     = 2;
	localparam int EMPTY_W  = 3;
	localparam int SYNC_LEN = 2;
	localparam int LEN_W    = 14;
	localparam logic [LEN_W-1:0] MIN_LEN = 14'h0040;
	localparam logic [LEN_W-1:0] MAX_LEN = 14'h05EE;
	localparam logic [EMPTY_W-1:0] EMPTY_NONE = 3'h0;
	localparam logic [LEN_W-1:0] LEN_ZERO = 14'h0000;
	localparam logic [LEN_W-1:0] SEG_BYTES = 14'h0008;
endpackage

// *** rtl/rx_straddle_if.sv ***
/*
 Interface joining the device end and the client end of the receive stream.
 Assumes the testbench supplies the shared stream clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface rx_straddle_if
	import rx_straddle_pkg::*;
(
	input wire logic core_clk
);
	logic [WORD_W-1:0]  wordData;
	logic               wordValid;
	logic [SEGS-1:0]    segValid;
	logic [SEGS-1:0]    segFrameStart;
	logic [SEGS-1:0]    segFrameEnd;
	logic [SEGS-1:0]    segFrameBad;
	logic [EMPTY_W-1:0] segEmptyBytes [SEGS];
	modport device (
		input  core_clk,
		output wordData, wordValid, segValid, segFrameStart, segFrameEnd, segFrameBad, segEmptyBytes
	);
	modport client (
		input  core_clk,
		input  wordData, wordValid, segValid, segFrameStart, segFrameEnd, segFrameBad, segEmptyBytes
	);
endinterface
`default_nettype wire

// *** rtl/rx_straddle_device.sv ***
/*
 Device end: registers MAC-side segment beats onto the straddled stream, checks length and flags bad frames.
 Assumes the MAC core supplies beats already aligned, with FCS error flags at frame end and code error flags on any beat of the frame.
*/
`timescale 1ns/1ps
`default_nettype none
module rx_straddle_device
	import rx_straddle_pkg::*;
(
	input  wire logic               core_clk,
	input  wire logic               nrst,
	input  wire logic               rxReset,
	input  wire logic [WORD_W-1:0]  macData,
	input  wire logic [SEGS-1:0]    macSegValid,
	input  wire logic [SEGS-1:0]    macSegStart,
	input  wire logic [SEGS-1:0]    macSegEnd,
	input  wire logic [SEGS-1:0]    macFcsBad,
	input  wire logic [SEGS-1:0]    macCodeBad,
	input  wire logic [EMPTY_W-1:0] macSegEmpty [SEGS],
	output logic                    rxClkOut,
	output logic                    inReset,
	rx_straddle_if.device           link
);
	logic [SYNC_LEN-1:0] rstSync_r;
	logic [SYNC_LEN-1:0] rstSync_nxt;
	logic                rstIn;
	logic [WORD_W-1:0]   data_r, data_nxt;
	logic                valid_r, valid_nxt;
	logic [SEGS-1:0]     sv_r, sv_nxt, ss_r, ss_nxt, se_r, se_nxt, bad_r, bad_nxt;
	logic [EMPTY_W-1:0]  emp_r [SEGS];
	logic [EMPTY_W-1:0]  emp_nxt [SEGS];
	logic [LEN_W-1:0]    len_r, len_nxt;
	logic                codeSeen_r, codeSeen_nxt;
	// Reset comes in as an asynchronous level; resync before use
	always_comb rstSync_nxt = {rstSync_r[SYNC_LEN-2:0], rxReset};
	always_ff @(posedge core_clk or negedge nrst)
		if (!nrst)
			rstSync_r <= '1;
		else
			rstSync_r <= rstSync_nxt;
	assign rstIn = rstSync_r[SYNC_LEN-1];
	// Stream clock passed through; no gating so the client sees a free clock
	assign rxClkOut = core_clk;
	assign inReset = rstIn;
	always_comb
	begin
		logic [LEN_W-1:0] l;
		logic             c;
		logic [LEN_W-1:0] full;
		l = len_r;
		c = codeSeen_r;
		full = LEN_ZERO;
		data_nxt = macData;
		valid_nxt = |macSegValid;
		sv_nxt = macSegValid;
		ss_nxt = macSegStart & macSegValid;
		se_nxt = macSegEnd & macSegValid;
		bad_nxt = '0;
		for (int s = 0; s < SEGS; s++)
		begin
			emp_nxt[s] = EMPTY_NONE;
			if (macSegValid[s])
			begin
				if (macSegStart[s])
				begin
					l = LEN_ZERO;
					c = 1'b0;
				end
				c = c | macCodeBad[s];
				if (macSegEnd[s])
				begin
					full = l + SEG_BYTES - {{(LEN_W-EMPTY_W){1'b0}}, macSegEmpty[s]};
					emp_nxt[s] = macSegEmpty[s];
					bad_nxt[s] = macFcsBad[s] | c | (full < MIN_LEN) | (full > MAX_LEN);
					l = LEN_ZERO;
				end
				else
					l = l + SEG_BYTES;
			end
		end
		len_nxt = l;
		codeSeen_nxt = c;
		if (rstIn)
		begin
			valid_nxt = 1'b0;
			sv_nxt = '0;
			ss_nxt = '0;
			se_nxt = '0;
			bad_nxt = '0;
			len_nxt = LEN_ZERO;
			codeSeen_nxt = 1'b0;
			// Stale end counts would break the zero-outside-end promise
			for (int s = 0; s < SEGS; s++)
				emp_nxt[s] = EMPTY_NONE;
		end
	end
	// Registered every cycle: no stall path exists
	always_ff @(posedge core_clk or negedge nrst)
		if (!nrst)
		begin
			data_r <= '0;
			valid_r <= 1'b0;
			sv_r <= '0;
			ss_r <= '0;
			se_r <= '0;
			bad_r <= '0;
			len_r <= LEN_ZERO;
			codeSeen_r <= 1'b0;
			for (int s = 0; s < SEGS; s++)
				emp_r[s] <= EMPTY_NONE;
		end
		else
		begin
			data_r <= data_nxt;
			valid_r <= valid_nxt;
			sv_r <= sv_nxt;
			ss_r <= ss_nxt;
			se_r <= se_nxt;
			bad_r <= bad_nxt;
			len_r <= len_nxt;
			codeSeen_r <= codeSeen_nxt;
			for (int s = 0; s < SEGS; s++)
				emp_r[s] <= emp_nxt[s];
		end
	assign link.wordData = data_r;
	assign link.wordValid = valid_r;
	assign link.segValid = sv_r;
	assign link.segFrameStart = ss_r;
	assign link.segFrameEnd = se_r;
	assign link.segFrameBad = bad_r;
	generate
		for (genvar g = 0; g < SEGS; g++)
		begin : gEmp
			assign link.segEmptyBytes[g] = emp_r[g];
		end
	endgenerate
endmodule
`default_nettype wire

// *** rtl/rx_straddle_client.sv ***
/*
 Client end: accepts every beat and splits it into per-segment user outputs, registered.
 Assumes the device end drives the link from the same stream clock.
*/
`timescale 1ns/1ps
`default_nettype none
module rx_straddle_client
	import rx_straddle_pkg::*;
(
	input  wire logic               core_clk,
	input  wire logic               nrst,
	rx_straddle_if.client           link,
	output logic [SEG_W-1:0]        segData [SEGS],
	output logic [SEGS-1:0]         segValidOut,
	output logic [SEGS-1:0]         segStartOut,
	output logic [SEGS-1:0]         segEndOut,
	output logic [SEGS-1:0]         segBadOut,
	output logic [EMPTY_W-1:0]      segEmptyOut [SEGS]
);
	logic [SEG_W-1:0]   d_r [SEGS];
	logic [SEG_W-1:0]   d_nxt [SEGS];
	logic [SEGS-1:0]    v_r, v_nxt, s_r, s_nxt, e_r, e_nxt, b_r, b_nxt;
	logic [EMPTY_W-1:0] m_r [SEGS];
	logic [EMPTY_W-1:0] m_nxt [SEGS];
	// No ready exists; every cycle is sampled
	always_comb
	begin
		for (int g = 0; g < SEGS; g++)
		begin
			d_nxt[g] = link.wordData[WORD_W-1-g*SEG_W -: SEG_W];
			v_nxt[g] = link.wordValid & link.segValid[g];
			s_nxt[g] = v_nxt[g] & link.segFrameStart[g];
			e_nxt[g] = v_nxt[g] & link.segFrameEnd[g];
			b_nxt[g] = e_nxt[g] & link.segFrameBad[g];
			m_nxt[g] = e_nxt[g] ? link.segEmptyBytes[g] : EMPTY_NONE;
		end
	end
	always_ff @(posedge core_clk or negedge nrst)
		if (!nrst)
		begin
			v_r <= '0;
			s_r <= '0;
			e_r <= '0;
			b_r <= '0;
			for (int g = 0; g < SEGS; g++)
			begin
				d_r[g] <= '0;
				m_r[g] <= EMPTY_NONE;
			end
		end
		else
		begin
			v_r <= v_nxt;
			s_r <= s_nxt;
			e_r <= e_nxt;
			b_r <= b_nxt;
			for (int g = 0; g < SEGS; g++)
			begin
				d_r[g] <= d_nxt[g];
				m_r[g] <= m_nxt[g];
			end
		end
	assign segData = d_r;
	assign segValidOut = v_r;
	assign segStartOut = s_r;
	assign segEndOut = e_r;
	assign segBadOut = b_r;
	assign segEmptyOut = m_r;
endmodule
`default_nettype wire

// *** sim/rx_straddle_monitor.sv ***
/*
 Checker for the straddled receive link signals.
 Assumes it is placed beside the interface, on core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module rx_straddle_monitor
	import rx_straddle_pkg::*;
(
	input wire logic               core_clk,
	input wire logic               nrst,
	input wire logic               wordValid,
	input wire logic [SEGS-1:0]    segValid,
	input wire logic [SEGS-1:0]    segFrameStart,
	input wire logic [SEGS-1:0]    segFrameEnd,
	input wire logic [SEGS-1:0]    segFrameBad,
	input wire logic [EMPTY_W-1:0] segEmptyBytes [SEGS]
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	sequence open0;
		segValid[0] && !segFrameEnd[0];
	endsequence
	sequence open1;
		segValid[1] && !segFrameEnd[1];
	endsequence
	AST_WORD_VALID: assert property (wordValid == (|segValid))
		else $error("word valid differs from segment valids");
	AST_START_VALID: assert property ((segFrameStart & ~segValid) == 2'b00)
		else $error("start outside valid segment");
	AST_END_VALID: assert property ((segFrameEnd & ~segValid) == 2'b00)
		else $error("end outside valid segment");
	AST_BAD_AT_END: assert property ((segFrameBad & ~(segFrameEnd & segValid)) == 2'b00)
		else $error("bad flag outside end beat");
	AST_EMPTY0: assert property (segEmptyBytes[0] != 3'h0 |-> segValid[0] && segFrameEnd[0])
		else $error("segment 0 empty count outside end");
	AST_EMPTY1: assert property (segEmptyBytes[1] != 3'h0 |-> segValid[1] && segFrameEnd[1])
		else $error("segment 1 empty count outside end");
	AST_NEXT_BEAT: assert property (open1 |=> segValid[0])
		else $error("frame gap after segment 1");
	AST_SAME_BEAT: assert property (open0 |-> segValid[1])
		else $error("frame gap after segment 0");
endmodule
`default_nettype wire

// *** sim/tb.sv ***
/*
 Bench joining device end and client end through the link.
 Assumes nothing outside; makes clock and reset itself.
*/
`timescale 1ns/1ps
`default_nettype none
module tb
	import rx_straddle_pkg::*;
;
	logic core_clk = 0, nrst = 0, rxReset = 1, rxClkOut, inReset;
	logic [WORD_W-1:0] macData = '0;
	logic [SEGS-1:0] macSegValid = '0, macSegStart = '0, macSegEnd = '0, macFcsBad = '0, macCodeBad = '0;
	logic [EMPTY_W-1:0] macSegEmpty [SEGS] = '{default: '0};
	logic [EMPTY_W-1:0] segEmptyOut [SEGS];
	logic [SEG_W-1:0] segData [SEGS];
	logic [SEGS-1:0] segValidOut, segStartOut, segEndOut, segBadOut;
	logic [63:0] txCnt = '0, rxCnt = '0, cliCnt = '0;
	logic [3:0] lnkQ [$], cliQ [$];
	int pos = 0, num_errors = 0, check_count = 0;
	logic lnkOpen = 0, cliOpen = 0;
	// Auxiliary clock not modelled; stream clock is stable from time zero
	always #12.5 core_clk = ~core_clk;
	rx_straddle_if link (.core_clk(core_clk));
	rx_straddle_device rx_straddle_device_i (.core_clk(core_clk), .nrst(nrst), .rxReset(rxReset),
		.macData(macData), .macSegValid(macSegValid), .macSegStart(macSegStart), .macSegEnd(macSegEnd),
		.macFcsBad(macFcsBad), .macCodeBad(macCodeBad), .macSegEmpty(macSegEmpty), .rxClkOut(rxClkOut),
		.inReset(inReset), .link(link));
	rx_straddle_client rx_straddle_client_i (.core_clk(core_clk), .nrst(nrst), .link(link), .segData(segData),
		.segValidOut(segValidOut), .segStartOut(segStartOut), .segEndOut(segEndOut), .segBadOut(segBadOut),
		.segEmptyOut(segEmptyOut));
	rx_straddle_monitor rx_straddle_monitor_i (.core_clk(core_clk), .nrst(nrst), .wordValid(link.wordValid),
		.segValid(link.segValid), .segFrameStart(link.segFrameStart), .segFrameEnd(link.segFrameEnd),
		.segFrameBad(link.segFrameBad), .segEmptyBytes(link.segEmptyBytes));
	task automatic chk(input logic ok, input string msg);
		check_count++;
		if (ok !== 1'b1)
		begin
			num_errors++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask
	// One slot per call; each slot's bits set once a beat
	task automatic put(input logic v, s, e, input logic [2:0] m, input logic f, c);
		if (pos == 0) @(negedge core_clk);
		macData[SEG_W*(1-pos) +: SEG_W] = v ? txCnt : ~txCnt;
		{macSegValid[pos], macSegStart[pos], macSegEnd[pos], macFcsBad[pos], macCodeBad[pos]} = {v, s, e, f, c};
		macSegEmpty[pos] = m;
		txCnt += 64'(v);
		pos = 1 - pos;
	endtask
	task automatic frame(input int n, input logic [2:0] m, input logic f, c);
		int b;
		b = 8 * n - m;
		lnkQ.push_back({(b < MIN_LEN) || (b > MAX_LEN) || f || c, m});
		cliQ.push_back(lnkQ[$]);
		for (int i = 0; i < n; i++) put(1, i == 0, i == n - 1, i == n - 1 ? m : 3'h0, i == n - 1 && f, i == n - 1 && c);
	endtask
	task automatic flush(input int t);
		if (pos == 1) put(0, 0, 0, 0, 0, 0);
		put(0, 0, 0, 0, 0, 0);
		put(0, 0, 0, 0, 0, 0);
		for (int i = 0; i < 10 && lnkQ.size() + cliQ.size() > 0; i++) @(negedge core_clk);
		chk(lnkQ.size() + cliQ.size() == 0, "frame end missing");
		$display("test %0d done", t);
	endtask
	// Sampled at negedge so registered outputs have settled
	always @(negedge core_clk)
		for (int s = 0; s < SEGS; s++)
		begin
			if (link.segValid[s]) chk(link.wordData[SEG_W*(1-s) +: SEG_W] === rxCnt++, "link data");
			if (link.segValid[s] && link.segFrameEnd[s]) chk({link.segFrameBad[s], link.segEmptyBytes[s]} === lnkQ.pop_front(), "link end");
			if (link.segValid[s]) chk(link.segFrameStart[s] === !lnkOpen, "link start");
			if (link.segValid[s]) lnkOpen = !link.segFrameEnd[s];
			if (segValidOut[s]) chk(segData[s] === cliCnt++, "client data");
			if (segValidOut[s] && segEndOut[s]) chk({segBadOut[s], segEmptyOut[s]} === cliQ.pop_front(), "client end");
			if (segValidOut[s]) chk(segStartOut[s] === !cliOpen, "client start");
			if (segValidOut[s]) cliOpen = !segEndOut[s];
		end
	task end_of_test;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		repeat (5) @(negedge core_clk);
		nrst = 1;
		repeat (3) @(negedge core_clk);
		rxReset = 0;
		repeat (4) @(negedge core_clk);
		frame(8, 3'h0, 0, 0);
		frame(8, 3'h1, 0, 0);
		flush(1);
		put(0, 0, 0, 0, 0, 0);
		frame(190, 3'h2, 0, 0);
		frame(190, 3'h1, 0, 0);
		frame(10, 3'h4, 1, 0);
		frame(10, 3'h0, 0, 1);
		flush(2);
		rxReset = 1;
		// Valids raised only once the synchronized reset has taken hold
		repeat (3) @(negedge core_clk);
		macSegValid = 2'b11;
		repeat (2) @(negedge core_clk);
		chk(link.wordValid === 1'b0 && link.segValid === 2'b00 && inReset === 1'b1 && rxClkOut === core_clk, "reset hold");
		macSegValid = 2'b00;
		rxReset = 0;
		repeat (3) @(negedge core_clk);
		chk(inReset === 1'b0, "reset release");
		frame(9, 3'h7, 0, 0);
		flush(3);
		end_of_test();
	end
endmodule
`default_nettype wire
